/* hw/otp_device_port.sv */
// Device end: one-time-programmable code store, encryption table and
// security bits, with the core's fetch port on the user side.
// Assumes pins are asynchronous to hclk and the programmer keeps timing.
//
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
module otp_device_port #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value.
  parameter logic [7:0] SIG_BYTE1 = 8'ha5  // Arbitrary value.
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  otp_link_if.device                      lk,
  input  wire logic [otp_pkg::CODE_AW-1:0] core_addr,
  input  wire logic                       core_table_read,
  input  wire logic                       core_from_external,
  output logic      [7:0]                 core_data_q,
  output logic                            core_denied_q,
  output logic                            external_code_select_q,
  output logic                            ext_exec_allowed_q,
  output logic                            six_clock_mode_q
);
  localparam int PIN_W = 32;
  localparam int CODE_DEPTH = 1 << otp_pkg::CODE_AW;
  localparam int ENC_DEPTH = 1 << otp_pkg::ENC_AW;
  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] s1_q;
  logic [PIN_W-1:0] s2_q;
  logic [PIN_W-1:0] s3_q;
  logic [PIN_W-1:0] pin_q;
  logic [PIN_W-1:0] pin_d;
  assign pins_raw = {lk.prog_mode, lk.code_fetch_strobe_n,
                     lk.write_pulse_pin, lk.external_access_supply_pin,
                     lk.vpp_on, lk.mode_select_line_b,
                     lk.mode_select_line_a, lk.p3_3, lk.addr_hi,
                     lk.addr_lo, lk.p0};
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_agree
      assign pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
    end
  endgenerate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q  <= otp_pkg::PIN_IDLE;
      s2_q  <= otp_pkg::PIN_IDLE;
      s3_q  <= otp_pkg::PIN_IDLE;
      pin_q <= otp_pkg::PIN_IDLE;
    end else begin
      s1_q  <= pins_raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= pin_d;
    end
  end
  wire        in_prog  = pin_q[31] & ~pin_q[30];
  wire        wp       = pin_q[29];
  wire        ext_pin  = pin_q[28];
  wire        vpp      = pin_q[27];
  wire [3:0]  sel      = {pin_q[23], pin_q[22], pin_q[26], pin_q[25]};
  wire        p33      = pin_q[24];
  wire [15:0] addr     = pin_q[23:8];
  wire [7:0]  din      = pin_q[7:0];
  // ------------------------------------------------------------------
  // Nonvolatile state; kept across resets
  // ------------------------------------------------------------------
  logic [7:0] code_mem [CODE_DEPTH];
  logic [7:0] enc_mem  [ENC_DEPTH];
  logic [3:1] sb_q;
  logic       enc_used_q;
  logic       clk6_q;
  initial begin
    for (int i = 0; i < CODE_DEPTH; i++) code_mem[i] = 8'hff;
    for (int i = 0; i < ENC_DEPTH; i++) enc_mem[i] = 8'hff;
    sb_q       = 3'h0;
    enc_used_q = 1'b0;
    clk6_q     = 1'b0;
  end
  // ------------------------------------------------------------------
  // Pulse counting and commit
  // ------------------------------------------------------------------
  otp_pkg::mode_t mode;
  otp_pkg::mode_t mode_q;
  logic [15:0] addr_q;
  logic [2:0]  cnt_q;
  logic [2:0]  cnt_d;
  logic        wp_q;
  assign mode = in_prog ? otp_pkg::decode_mode(sel, vpp, p33)
                        : otp_pkg::M_NONE;
  wire fall   = wp_q & ~wp;
  wire rise   = ~wp_q & wp;
  wire same   = (mode == mode_q) && (addr == addr_q);
  wire commit = same && rise && (cnt_q == otp_pkg::PULSES);
  wire lock   = |sb_q;
  assign cnt_d = (!same || !otp_pkg::is_pgm(mode) || commit) ? 3'h0
               : (fall ? cnt_q + 3'h1 : cnt_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q   <= 1'b1;
      cnt_q  <= 3'h0;
      mode_q <= otp_pkg::M_NONE;
      addr_q <= 16'h0000;
    end else begin
      wp_q   <= wp;
      cnt_q  <= cnt_d;
      mode_q <= mode;
      addr_q <= addr;
    end
  end
  always @(posedge hclk) begin
    if (commit) begin
      case (mode)
        otp_pkg::M_PGM_CODE: if (!lock) begin
          code_mem[addr[otp_pkg::CODE_AW-1:0]] <= din;
        end
        otp_pkg::M_PGM_ENC: if (!lock) begin
          enc_mem[addr[otp_pkg::ENC_AW-1:0]] <= din;
          enc_used_q <= 1'b1;
        end
        otp_pkg::M_PGM_6CLK: if (!lock) begin
          clk6_q <= 1'b1;
        end
        otp_pkg::M_PGM_SB1: sb_q[1] <= 1'b1;
        otp_pkg::M_PGM_SB2: sb_q[2] <= 1'b1;
        otp_pkg::M_PGM_SB3: sb_q[3] <= 1'b1;
        default: ;
      endcase
    end
  end
  // ------------------------------------------------------------------
  // Verify and signature output on port 0
  // ------------------------------------------------------------------
  wire [7:0] code_b = code_mem[addr[otp_pkg::CODE_AW-1:0]];
  wire [7:0] enc_b  = enc_mem[addr[otp_pkg::ENC_AW-1:0]];
  wire       vfy_ok = ~sb_q[2] & ~sb_q[3];
  logic [7:0] vfy_byte;
  logic       vfy_en;
  always_comb begin
    vfy_byte = 8'hff;
    vfy_en   = 1'b0;
    case (mode)
      otp_pkg::M_VFY_CODE: begin
        vfy_en   = vfy_ok;
        vfy_byte = enc_used_q ? ~(code_b ^ enc_b) : code_b;
      end
      otp_pkg::M_SIG: begin
        vfy_en = 1'b1;
        if (addr == otp_pkg::SIG_ADDR0) begin
          vfy_byte = SIG_BYTE0;
        end else if (addr == otp_pkg::SIG_ADDR1) begin
          vfy_byte = SIG_BYTE1;
        end
      end
      otp_pkg::M_VFY_SB: begin
        vfy_en = 1'b1;
        vfy_byte[otp_pkg::SB1_POS] = sb_q[1];
        vfy_byte[otp_pkg::SB2_POS] = sb_q[2];
        vfy_byte[otp_pkg::SB3_POS] = sb_q[3];
      end
      otp_pkg::M_VFY_6CLK: begin
        vfy_en = 1'b1;
        vfy_byte[otp_pkg::CLK6_POS] = ~clk6_q;
      end
      default: ;
    endcase
  end
  // ------------------------------------------------------------------
  // Core fetch side and external-access latch
  // ------------------------------------------------------------------
  logic [2:0] settle_q;
  wire        settled = (settle_q == otp_pkg::SYNC_SETTLE);
  wire  deny = core_from_external & (core_table_read & sb_q[1] | sb_q[3]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lk.p0_dev_out          <= 8'hff;
      lk.p0_dev_oe           <= 1'b0;
      core_data_q            <= 8'h00;
      core_denied_q          <= 1'b0;
      external_code_select_q <= 1'b0;
      settle_q               <= 3'h0;
      ext_exec_allowed_q     <= 1'b0;
      six_clock_mode_q       <= 1'b0;
    end else begin
      lk.p0_dev_out      <= vfy_byte;
      lk.p0_dev_oe       <= vfy_en;
      core_denied_q      <= deny;
      core_data_q        <= deny ? 8'h00 : code_mem[core_addr];
      ext_exec_allowed_q <= ~sb_q[3];
      six_clock_mode_q   <= clk6_q;
      settle_q           <= settled ? settle_q : settle_q + 3'h1;
      if (!settled || !sb_q[1]) begin
        external_code_select_q <= ~ext_pin;
      end
    end
  end
endmodule

/* hw/otp_pkg.sv */
// Constants, modes and pin-level codes of the code-memory programming port.
// Assumes a 10 MHz hclk on both ends and one programmer per device.
package otp_pkg;
  localparam int CODE_AW = 14;
  localparam int ENC_AW  = 6;
  localparam logic [2:0] PULSES = 3'h5;
  localparam logic [15:0] SIG_ADDR0 = 16'h0030;
  localparam logic [15:0] SIG_ADDR1 = 16'h0031;
  localparam int SB1_POS = 7;
  localparam int SB2_POS = 6;
  localparam int SB3_POS = 3;
  localparam int CLK6_POS = 4;
  localparam logic [31:0] PIN_IDLE    = 32'h7100_00ff;
  localparam logic [2:0]  SYNC_SETTLE = 3'h5;
  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_NS        = 100;
  localparam int PULSE_LOW_NS  = 100000;
  localparam int PULSE_HIGH_NS = 10000;
  localparam int SETUP_NS      = 12000;
  localparam int PULSE_LOW_CYC  = PULSE_LOW_NS / CLK_NS;
  localparam int PULSE_HIGH_CYC = (PULSE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC      = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // ------------------------------------------------------------------
  // Programmer registers
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_EN_POS = 0;
  localparam int CTRL_GO_POS = 1;
  localparam int CTRL_OP_LSB = 4;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_DONE_POS = 1;
  // ------------------------------------------------------------------
  // Modes; select is {addr_hi[7], addr_hi[6], line_b, line_a}
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    M_NONE, M_SIG, M_PGM_CODE, M_VFY_CODE, M_PGM_ENC, M_PGM_SB1,
    M_PGM_SB2, M_PGM_SB3, M_PGM_6CLK, M_VFY_6CLK, M_VFY_SB
  } mode_t;
  function automatic mode_t decode_mode(input logic [3:0] sel,
                                        input logic vpp,
                                        input logic p33);
    mode_t m;
    m = M_NONE;
    if (vpp) begin
      case (sel)
        4'hb: m = M_PGM_CODE;
        4'ha: m = M_PGM_ENC;
        4'hf: m = M_PGM_SB1;
        4'hc: m = M_PGM_SB2;
        4'h5: m = M_PGM_SB3;
        4'h2: m = p33 ? M_NONE : M_PGM_6CLK;
        default: m = M_NONE;
      endcase
    end else begin
      case (sel)
        4'h0: m = M_SIG;
        4'h3: m = M_VFY_CODE;
        4'h1: m = p33 ? M_VFY_6CLK : M_NONE;
        4'h2: m = M_VFY_SB;
        default: m = M_NONE;
      endcase
    end
    return m;
  endfunction
  function automatic logic [4:0] encode_mode(input mode_t m);
    logic [4:0] s;
    s = 5'h00;
    case (m)
      M_SIG:      s = 5'h00;
      M_PGM_CODE: s = 5'h0b;
      M_VFY_CODE: s = 5'h03;
      M_PGM_ENC:  s = 5'h0a;
      M_PGM_SB1:  s = 5'h0f;
      M_PGM_SB2:  s = 5'h0c;
      M_PGM_SB3:  s = 5'h05;
      M_PGM_6CLK: s = 5'h02;
      M_VFY_6CLK: s = 5'h11;
      M_VFY_SB:   s = 5'h02;
      default:    s = 5'h00;
    endcase
    return s;
  endfunction
  function automatic logic is_pgm(input mode_t m);
    return m inside {M_PGM_CODE, M_PGM_ENC, M_PGM_SB1, M_PGM_SB2,
                     M_PGM_SB3, M_PGM_6CLK};
  endfunction
endpackage

/* hw/otp_link_if.sv */
// Pins between the programmer and the device in programming mode.
// Port 0 has pull-ups: undriven lines read as one.
`timescale 1ns/1ps
interface otp_link_if;
  logic       prog_mode;
  logic       code_fetch_strobe_n;
  logic       write_pulse_pin;
  logic       external_access_supply_pin;
  logic       vpp_on;
  logic       mode_select_line_a;
  logic       mode_select_line_b;
  logic       p3_3;
  logic [7:0] addr_lo;
  logic [7:0] addr_hi;
  logic [7:0] p0_prog_out;
  logic       p0_prog_oe;
  logic [7:0] p0_dev_out;
  logic       p0_dev_oe;
  logic [7:0] p0;
  assign p0 = p0_dev_oe ? p0_dev_out : (p0_prog_oe ? p0_prog_out : 8'hff);
  modport device (
    input  prog_mode, code_fetch_strobe_n, write_pulse_pin,
           external_access_supply_pin, vpp_on, mode_select_line_a,
           mode_select_line_b, p3_3, addr_lo, addr_hi, p0,
    output p0_dev_out, p0_dev_oe
  );
  modport programmer (
    output prog_mode, code_fetch_strobe_n, write_pulse_pin,
           external_access_supply_pin, vpp_on, mode_select_line_a,
           mode_select_line_b, p3_3, addr_lo, addr_hi, p0_prog_out,
           p0_prog_oe,
    input  p0
  );
endinterface

/* hw/otp_programmer.sv */
// Programmer end: AHB-Lite register slave that runs one program or
// verify operation on the device pins per start command.
// Assumes a single AHB-Lite master issuing single word transfers.
`timescale 1ns/1ps
module otp_programmer (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  otp_link_if.programmer   lk
);
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_LOW, S_HIGH, S_HOLD, S_SAMPLE
  } state_t;
  // ------------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------------
  logic        ap_wr_q;
  logic [7:0]  ap_addr_q;
  logic        en_q;
  logic [3:0]  op_q;
  logic [15:0] addr_q;
  logic [7:0]  wdata_q;
  logic [7:0]  rdata_q;
  logic        done_q;
  state_t      st_q;
  wire         busy = (st_q != S_IDLE);
  wire         take = hsel & hready & htrans[1];
  wire [7:0]   roff = haddr[7:0];
  wire         wr_ctrl = ap_wr_q && (ap_addr_q == otp_pkg::REG_CTRL);
  wire         go = wr_ctrl & hwdata[otp_pkg::CTRL_GO_POS] & ~busy & en_q;
  wire         clr_done = ap_wr_q && (ap_addr_q == otp_pkg::REG_STATUS)
                          && hwdata[otp_pkg::ST_DONE_POS];
  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    case (roff)
      otp_pkg::REG_CTRL:   rd_val = {24'h0, op_q, 3'h0, en_q};
      otp_pkg::REG_ADDR:   rd_val = {16'h0, addr_q};
      otp_pkg::REG_WDATA:  rd_val = {24'h0, wdata_q};
      otp_pkg::REG_RDATA:  rd_val = {24'h0, rdata_q};
      otp_pkg::REG_STATUS: rd_val = {30'h0, done_q, busy};
      default:             rd_val = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      en_q      <= 1'b0;
      op_q      <= 4'h0;
      addr_q    <= 16'h0000;
      wdata_q   <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      ap_wr_q   <= take & hwrite;
      ap_addr_q <= roff;
      if (take && !hwrite) begin
        hrdata <= rd_val;
      end
      if (wr_ctrl && !busy) begin
        en_q <= hwdata[otp_pkg::CTRL_EN_POS];
        op_q <= hwdata[otp_pkg::CTRL_OP_LSB +: 4];
      end
      if (ap_wr_q && !busy && ap_addr_q == otp_pkg::REG_ADDR) begin
        addr_q <= hwdata[15:0];
      end
      if (ap_wr_q && !busy && ap_addr_q == otp_pkg::REG_WDATA) begin
        wdata_q <= hwdata[7:0];
      end
    end
  end
  // ------------------------------------------------------------------
  // Pin sequencer
  // ------------------------------------------------------------------
  otp_pkg::mode_t op_mode;
  logic [4:0]  sel_code;
  logic [10:0] tmr_q;
  logic [2:0]  np_q;
  logic [7:0]  p0_s1_q;
  logic [7:0]  p0_s2_q;
  logic [7:0]  p0_s3_q;
  wire [3:0] op_next = go ? hwdata[otp_pkg::CTRL_OP_LSB +: 4] : op_q;
  assign op_mode  = otp_pkg::mode_t'(op_next);
  assign sel_code = otp_pkg::encode_mode(op_mode);
  wire pgm     = otp_pkg::is_pgm(op_mode);
  wire tmr_end = (tmr_q == 11'h000);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q    <= S_IDLE;
      tmr_q   <= 11'h000;
      np_q    <= 3'h0;
      done_q  <= 1'b0;
      rdata_q <= 8'h00;
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
      p0_s3_q <= 8'h00;
      lk.prog_mode                  <= 1'b0;
      lk.code_fetch_strobe_n        <= 1'b1;
      lk.write_pulse_pin            <= 1'b1;
      lk.external_access_supply_pin <= 1'b1;
      lk.vpp_on                     <= 1'b0;
      lk.mode_select_line_a         <= 1'b0;
      lk.mode_select_line_b         <= 1'b0;
      lk.p3_3                       <= 1'b1;
      lk.addr_lo                    <= 8'h00;
      lk.addr_hi                    <= 8'h00;
      lk.p0_prog_out                <= 8'h00;
      lk.p0_prog_oe                 <= 1'b0;
    end else begin
      p0_s1_q <= lk.p0;
      p0_s2_q <= p0_s1_q;
      p0_s3_q <= p0_s2_q;
      lk.prog_mode           <= en_q;
      lk.code_fetch_strobe_n <= ~en_q;
      if (!tmr_end) begin
        tmr_q <= tmr_q - 11'h001;
      end
      if (clr_done && !(st_q == S_HOLD || st_q == S_SAMPLE) || go) begin
        done_q <= 1'b0;
      end
      case (st_q)
        S_IDLE: if (go) begin
          lk.addr_lo <= addr_q[7:0];
          lk.addr_hi <= {sel_code[3:2], addr_q[13:8]};
          lk.mode_select_line_b <= sel_code[1];
          lk.mode_select_line_a <= sel_code[0];
          lk.p3_3 <= sel_code[4] | ~pgm;
          lk.p0_prog_out <= wdata_q;
          lk.p0_prog_oe <= pgm;
          lk.vpp_on <= pgm;
          np_q <= 3'h0;
          tmr_q <= 11'(otp_pkg::SETUP_CYC);
          st_q <= S_SETUP;
        end
        S_SETUP: if (tmr_end) begin
          if (pgm) begin
            lk.write_pulse_pin <= 1'b0;
            tmr_q <= 11'(otp_pkg::PULSE_LOW_CYC - 1);
            st_q <= S_LOW;
          end else begin
            st_q <= S_SAMPLE;
          end
        end
        S_LOW: if (tmr_end) begin
          lk.write_pulse_pin <= 1'b1;
          np_q <= np_q + 3'h1;
          tmr_q <= 11'(otp_pkg::PULSE_HIGH_CYC - 1);
          st_q <= S_HIGH;
        end
        S_HIGH: if (tmr_end) begin
          if (np_q == otp_pkg::PULSES) begin
            lk.vpp_on <= 1'b0;
            tmr_q <= 11'(otp_pkg::SETUP_CYC);
            st_q <= S_HOLD;
          end else begin
            lk.write_pulse_pin <= 1'b0;
            tmr_q <= 11'(otp_pkg::PULSE_LOW_CYC - 1);
            st_q <= S_LOW;
          end
        end
        S_HOLD: if (tmr_end) begin
          lk.p0_prog_oe <= 1'b0;
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
        S_SAMPLE: begin
          rdata_q <= p0_s3_q;
          done_q <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

/* verification/otp_sva.sv */
// Assertions on the pins that join the programmer and the device.
// Assumes a 10 MHz hclk and the signal names of the link interface.
`timescale 1ns/1ps
module otp_sva #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a // Arbitrary value.
) (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       prog_mode,
  input wire logic       code_fetch_strobe_n,
  input wire logic       write_pulse_pin,
  input wire logic       vpp_on,
  input wire logic       mode_select_line_a,
  input wire logic       mode_select_line_b,
  input wire logic [7:0] addr_lo,
  input wire logic [7:0] addr_hi,
  input wire logic       p0_prog_oe,
  input wire logic [7:0] p0_dev_out,
  input wire logic       p0_dev_oe
);
  logic [3:0]  sel;
  logic [15:0] addr;
  logic [11:0] lo_cnt_q;
  logic [11:0] hi_cnt_q;
  logic [11:0] vpp_cnt_q;
  logic [2:0]  pls_q;
  assign sel = {addr_hi[7], addr_hi[6], mode_select_line_b,
                mode_select_line_a};
  assign addr = {addr_hi, addr_lo};
  // Counts low time, high time, supply time and pulses per supply phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lo_cnt_q <= 12'h000;
      hi_cnt_q <= 12'hfff;
      vpp_cnt_q <= 12'h000;
      pls_q <= 3'h0;
    end else begin
      lo_cnt_q <= write_pulse_pin ? 12'h000 : lo_cnt_q + 12'h001;
      hi_cnt_q <= !write_pulse_pin ? 12'h000 :
                  hi_cnt_q + {11'h000, hi_cnt_q != 12'hfff};
      vpp_cnt_q <= !vpp_on ? 12'h000 :
                   vpp_cnt_q + {11'h000, vpp_cnt_q != 12'hfff};
      pls_q <= !vpp_on ? 3'h0 : pls_q + {2'h0, $fell(write_pulse_pin)};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pulse_low_width: assert property (
    $rose(write_pulse_pin) |-> lo_cnt_q inside {[900:1100]})
    else $error("write pulse low time out of range");
  a_pulse_high_gap: assert property (
    $fell(write_pulse_pin) |-> hi_cnt_q >= 12'd100)
    else $error("write pulse high time too short");
  a_supply_setup: assert property (
    $fell(write_pulse_pin) |-> vpp_cnt_q >= 12'd100)
    else $error("supply not settled before write pulse");
  a_five_pulses: assert property (
    $fell(vpp_on) |-> pls_q == 3'h5)
    else $error("supply phase without exactly five pulses");
  a_pulse_under_supply: assert property (
    !write_pulse_pin |-> vpp_on && prog_mode && p0_prog_oe && $stable(addr))
    else $error("write pulse outside a steady program phase");
  a_sig_byte: assert property (
    (prog_mode && !vpp_on && !code_fetch_strobe_n && sel == 4'h0 &&
     addr == 16'h0030) [*8] |=> p0_dev_oe && p0_dev_out == SIG_BYTE0)
    else $error("signature byte not returned");
  a_table_hidden: assert property (
    (vpp_on && sel == 4'ha) [*8] |=> !p0_dev_oe)
    else $error("device drives port during table write");
  a_lock_lines: assert property (
    (prog_mode && !vpp_on && !code_fetch_strobe_n && sel == 4'h2) [*8]
    |=> p0_dev_oe && (p0_dev_out | 8'hc8) == 8'hff)
    else $error("security verify lines wrong");
endmodule

/* verification/tb.sv */
// Bench: programmer and device joined by the link, driven over AHB-Lite.
// Assumes the bench is the only bus master and hclk runs at 10 MHz.
`timescale 1ns/1ps
module tb;
  localparam logic [7:0] SIG0 = 8'h5a; // Arbitrary value.
  localparam logic [7:0] SIG1 = 8'ha5; // Arbitrary value.
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic [13:0] core_addr = 14'h0;
  logic        core_table_read = 1'b0;
  logic        core_from_external = 1'b0;
  logic [7:0]  core_data_q;
  logic        core_denied_q;
  logic        ext_exec_allowed_q;
  logic        external_code_select_q;
  logic        six_clock_mode_q;
  int          n_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  otp_link_if lk ();
  otp_programmer u_otp_programmer (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .lk(lk.programmer));
  otp_device_port #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1)) u_otp_device_port (
    .hclk(hclk), .hresetn(hresetn), .lk(lk.device), .core_addr(core_addr),
    .core_table_read(core_table_read),
    .core_from_external(core_from_external), .core_data_q(core_data_q),
    .core_denied_q(core_denied_q),
    .external_code_select_q(external_code_select_q),
    .ext_exec_allowed_q(ext_exec_allowed_q),
    .six_clock_mode_q(six_clock_mode_q));
  otp_sva #(.SIG_BYTE0(SIG0)) u_otp_sva (.hclk(hclk), .hresetn(hresetn),
    .prog_mode(lk.prog_mode), .code_fetch_strobe_n(lk.code_fetch_strobe_n),
    .write_pulse_pin(lk.write_pulse_pin), .vpp_on(lk.vpp_on),
    .mode_select_line_a(lk.mode_select_line_a),
    .mode_select_line_b(lk.mode_select_line_b), .addr_lo(lk.addr_lo),
    .addr_hi(lk.addr_hi), .p0_prog_oe(lk.p0_prog_oe),
    .p0_dev_out(lk.p0_dev_out), .p0_dev_oe(lk.p0_dev_oe));
  always #50 hclk = ~hclk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic op(input otp_pkg::mode_t m, input logic [15:0] a,
                    input logic [7:0] d, output logic [7:0] r);
    logic [31:0] x;
    int          n;
    ahb(1'b1, otp_pkg::REG_ADDR, {16'h0, a}, x);
    ahb(1'b1, otp_pkg::REG_WDATA, {24'h0, d}, x);
    ahb(1'b1, otp_pkg::REG_CTRL, {24'h0, m, 4'h3}, x);
    n = 0;
    x = 32'h0;
    while (x[1] !== 1'b1 && n < 8000) begin
      ahb(1'b0, otp_pkg::REG_STATUS, 32'h0, x);
      n = n + 1;
    end
    chk({31'h0, x[1]}, 32'h1);
    ahb(1'b0, otp_pkg::REG_RDATA, 32'h0, x);
    r = x[7:0];
  endtask
  task automatic vfy(input otp_pkg::mode_t m, input logic [15:0] a,
                     input logic [7:0] e);
    logic [7:0] r;
    op(m, a, 8'h00, r);
    chk({24'h0, r}, {24'h0, e});
  endtask
  task automatic fetch(input logic tr, input logic ext, input logic [8:0] e);
    core_addr <= 14'h0005;
    core_table_read <= tr;
    core_from_external <= ext;
    repeat (3) @(posedge hclk);
    #1;
    chk({23'h0, core_denied_q, core_data_q}, {23'h0, e});
    @(posedge hclk);
  endtask
  task automatic do_reset;
    logic [31:0] x;
    hresetn <= 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b1, otp_pkg::REG_CTRL, 32'h1, x);
  endtask
  task automatic t_bus;
    logic [31:0] x;
    ahb(1'b0, 8'h20, 32'h0, x);
    chk(x, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    vfy(otp_pkg::M_SIG, 16'h0030, SIG0);
    vfy(otp_pkg::M_SIG, 16'h0031, SIG1);
  endtask
  task automatic t_program;
    logic [7:0] r;
    vfy(otp_pkg::M_VFY_CODE, 16'h0005, 8'hff);
    vfy(otp_pkg::M_VFY_6CLK, 16'h0000, 8'hff);
    op(otp_pkg::M_PGM_6CLK, 16'h0000, 8'h00, r);
    vfy(otp_pkg::M_VFY_6CLK, 16'h0000, 8'hef);
    chk({31'h0, six_clock_mode_q}, 32'h1);
    op(otp_pkg::M_PGM_CODE, 16'h0005, 8'h3c, r);
    vfy(otp_pkg::M_VFY_CODE, 16'h0005, 8'h3c);
    fetch(1'b0, 1'b0, 9'h03c);
  endtask
  task automatic t_encrypt;
    logic [7:0] r;
    op(otp_pkg::M_PGM_ENC, 16'h0005, 8'hf0, r);
    vfy(otp_pkg::M_VFY_CODE, 16'h0005, 8'h33);
    vfy(otp_pkg::M_VFY_CODE, 16'h0006, 8'hff);
  endtask
  task automatic t_locks;
    logic [7:0] r;
    vfy(otp_pkg::M_VFY_SB, 16'h0000, 8'h37);
    op(otp_pkg::M_PGM_SB1, 16'h0000, 8'h00, r);
    vfy(otp_pkg::M_VFY_SB, 16'h0000, 8'hb7);
    op(otp_pkg::M_PGM_CODE, 16'h0007, 8'h00, r);
    vfy(otp_pkg::M_VFY_CODE, 16'h0007, 8'hff);
    vfy(otp_pkg::M_VFY_CODE, 16'h0005, 8'h33);
    fetch(1'b1, 1'b1, 9'h100);
    fetch(1'b0, 1'b1, 9'h03c);
    op(otp_pkg::M_PGM_SB2, 16'h0000, 8'h00, r);
    vfy(otp_pkg::M_VFY_SB, 16'h0000, 8'hf7);
    vfy(otp_pkg::M_VFY_CODE, 16'h0005, 8'hff);
    do_reset();
    fetch(1'b1, 1'b1, 9'h100);
    chk({31'h0, external_code_select_q}, 32'h0);
    op(otp_pkg::M_PGM_SB3, 16'h0000, 8'h00, r);
    vfy(otp_pkg::M_VFY_SB, 16'h0000, 8'hff);
    chk({31'h0, ext_exec_allowed_q}, 32'h0);
    fetch(1'b0, 1'b1, 9'h100);
  endtask
  initial begin
    do_reset();
    t_bus();
    t_program();
    t_encrypt();
    t_locks();
    report_and_stop();
  end
endmodule
